// *** hdl/bcl_top.sv ***
// Breaker status, close latch and reclose supervision logic with register port
`include "bcl_defs.svh"
module bcl_top #(
  parameter int unsigned TICK_CLKS = (`BCL_PI_NS + `BCL_CLK_NS - 1) / `BCL_CLK_NS
) (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  // Register port
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [31:0] reg_rdata_out,
  // Breaker auxiliary contact pin
  input  wire logic        first_opto_input_in,
  // Protection and reclosing logic inputs
  input  wire logic        trip_in,
  input  wire logic        close_ext_in,
  input  wire logic        unlatch_ext_in,
  input  wire logic        reclose_initiate_in,
  input  wire logic        reclose_oi_timeout_in,
  input  wire logic        reclose_supervision_cond_in,
  input  wire logic        reclose_lockout_in,
  // Outputs
  output logic             close_output_contact_out,
  output logic             breaker_closed_status_out,
  output logic             close_failure_flag_out,
  output logic             close_cmd_pulse_out,
  output logic             supervision_fail_pulse_out,
  output logic             reclose_defeat_out,
  output logic             irq_out
);

  //////////////////////////////////////////////////////////////////////////////
  // Address decode helper
  function automatic logic bcl_hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Processing interval tick divider
  localparam int unsigned TW = $clog2(TICK_CLKS + 1);
  logic [TW-1:0] div_q;
  logic          tick_q;

  // One-cycle tick every interval; plant logic advances on it, except the defeat flop and the timeout edge capture
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else if (div_q == TW'(TICK_CLKS - 1)) begin
      div_q  <= '0;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser
  logic opto_s1_q;
  logic opto_s2_q;

  // Contact input is asynchronous; only the second stage is read
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      opto_s1_q <= 1'b0;
      opto_s2_q <= 1'b0;
    end else begin
      opto_s1_q <= first_opto_input_in;
      opto_s2_q <= opto_s1_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register file
  logic [7:0]  ctrl_q;
  logic [15:0] cfd_q;
  logic [15:0] deb_q;
  logic [15:0] win_q;
  logic [3:0]  mask_q;
  logic        cmd_pend_q;

  // Software writes; reset values give the default equations
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_q <= `BCL_CTRL_RST;
      cfd_q  <= `BCL_CFD_RST;
      deb_q  <= `BCL_DEB_RST;
      win_q  <= `BCL_WIN_RST;
      mask_q <= `BCL_MASK_RST;
    end else if (reg_wr_in) begin
      if (bcl_hit(reg_addr_in, `BCL_ADR_CTRL)) ctrl_q <= reg_wdata_in[7:0];
      if (bcl_hit(reg_addr_in, `BCL_ADR_CFD))  cfd_q  <= reg_wdata_in[15:0];
      if (bcl_hit(reg_addr_in, `BCL_ADR_DEB))  deb_q  <= reg_wdata_in[15:0];
      if (bcl_hit(reg_addr_in, `BCL_ADR_WIN))  win_q  <= reg_wdata_in[15:0];
      if (bcl_hit(reg_addr_in, `BCL_ADR_MASK)) mask_q <= reg_wdata_in[3:0];
    end
  end

  // Close command waits for the next tick; a write in the tick cycle is kept
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cmd_pend_q <= 1'b0;
    end else if (reg_wr_in && bcl_hit(reg_addr_in, `BCL_ADR_CMD) && reg_wdata_in[`BCL_CMD_CLOSE]) begin
      cmd_pend_q <= 1'b1;
    end else if (tick_q) begin
      cmd_pend_q <= 1'b0;
    end
  end

  // Field views
  bcl_pkg::bcl_bkr_src_t bkr_src;
  bcl_pkg::bcl_ul_src_t  ul_src;
  logic                  cl_src_ext;
  logic                  cfd_off;
  logic                  win_off;
  assign bkr_src    = bcl_pkg::bcl_bkr_src_t'(ctrl_q[`BCL_CTL_BKR]);
  assign ul_src     = bcl_pkg::bcl_ul_src_t'(ctrl_q[`BCL_CTL_UL]);
  assign cl_src_ext = ctrl_q[`BCL_CTL_CL];
  assign cfd_off    = ctrl_q[`BCL_CTL_CFD_OFF];
  assign win_off    = ctrl_q[`BCL_CTL_WIN_OFF];

  //////////////////////////////////////////////////////////////////////////////
  // Timers
  bcl_tmr_if #(.LW(18)) deb_if ();
  bcl_tmr_if #(.LW(18)) drop_if ();
  bcl_tmr_if #(.LW(18)) cf_if ();
  bcl_tmr_if #(.LW(18)) win_if ();

  bcl_timer #(.LW(18)) u_deb (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .tick_in(tick_q), .tif(deb_if));
  bcl_timer #(.LW(18)) u_drop (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .tick_in(tick_q), .tif(drop_if));
  bcl_timer #(.LW(18)) u_cf (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .tick_in(tick_q), .tif(cf_if));
  bcl_timer #(.LW(18)) u_win (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .tick_in(tick_q), .tif(win_if));

  //////////////////////////////////////////////////////////////////////////////
  // Breaker status
  logic deb_st_q;
  logic bkr_q;
  logic bkr_eq;
  logic bkr_d;

  // Debounce both edges of the contact
  assign deb_if.run   = opto_s2_q != deb_st_q;
  assign deb_if.limit = {2'b00, deb_q};
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      deb_st_q <= 1'b0;
    end else if (tick_q && deb_if.expired) begin
      deb_st_q <= opto_s2_q;
    end
  end

  // Equation: constant, a-contact or b-contact
  always_comb begin
    unique case (bkr_src)
      bcl_pkg::BCL_BKR_ZERO: bkr_eq = 1'b0;
      bcl_pkg::BCL_BKR_NORM: bkr_eq = deb_st_q;
      bcl_pkg::BCL_BKR_INV:  bkr_eq = !deb_st_q;
      bcl_pkg::BCL_BKR_ONE:  bkr_eq = 1'b1;
    endcase
  end

  // Pickup at once, dropout only after the half-cycle timer
  assign drop_if.run   = bkr_q && !bkr_eq;
  assign drop_if.limit = 18'(`BCL_DROPOUT_PI);
  assign bkr_d         = bkr_eq || (bkr_q && !drop_if.expired);
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      bkr_q <= 1'b0;
    end else if (tick_q) begin
      bkr_q <= bkr_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Equations and edge detectors
  logic cc_q;
  logic cl_prev_q;
  logic ri_prev_q;
  logic oi_pend_q;
  logic oit_prev_q;
  logic defeat_q;
  logic cl_eq;
  logic ul_eq;
  logic cl_rise;
  logic ri_rise;
  logic inop;

  // Command pulse is one interval wide; the request equation and close_cmd_pulse_out read it
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cc_q <= 1'b0;
    end else if (tick_q) begin
      cc_q <= cmd_pend_q;
    end
  end

  assign cl_eq = cl_src_ext ? close_ext_in : cc_q;

  // Unlatch equation source
  always_comb begin
    unique case (ul_src)
      bcl_pkg::BCL_UL_TRIP: ul_eq = trip_in;
      bcl_pkg::BCL_UL_ONE:  ul_eq = 1'b1;
      bcl_pkg::BCL_UL_ZERO: ul_eq = 1'b0;
      bcl_pkg::BCL_UL_EXT:  ul_eq = unlatch_ext_in;
    endcase
  end

  // Previous-interval samples for rising-edge detection
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cl_prev_q <= 1'b0;
      ri_prev_q <= 1'b0;
    end else if (tick_q) begin
      cl_prev_q <= cl_eq;
      ri_prev_q <= reclose_initiate_in;
    end
  end
  assign cl_rise = cl_eq && !cl_prev_q;
  assign ri_rise = reclose_initiate_in && !ri_prev_q;

  // Permanent defeat; a held-high external unlatch cannot be seen as constant
  assign inop = (bkr_src == bcl_pkg::BCL_BKR_ZERO) || (ul_src == bcl_pkg::BCL_UL_ONE);

  // Defeat indication from a flop, one clock after the control write
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      defeat_q <= 1'b0;
    end else begin
      defeat_q <= inop;
    end
  end

  // Timeout edge held until the next tick; set wins, and a long pulse counts only once
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      oit_prev_q <= 1'b0;
      oi_pend_q  <= 1'b0;
    end else begin
      oit_prev_q <= reclose_oi_timeout_in;
      if (reclose_oi_timeout_in && !oit_prev_q) begin
        oi_pend_q <= 1'b1;
      end else if (tick_q) begin
        oi_pend_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reclose supervision
  bcl_pkg::bcl_sup_st_t sup_st_q;
  logic                 sfail_q;
  logic                 close_q;
  logic                 win_zero;
  logic                 seal_ok;
  logic                 sup_clr;
  logic                 recl;
  logic                 sfail_d;

  assign win_zero     = (win_q == 16'h0000) && !win_off;
  assign seal_ok      = !close_q && !reclose_lockout_in && !bkr_q && !ri_rise && !sfail_q && !inop;
  assign sup_clr      = close_q || reclose_lockout_in || bkr_q || ri_rise
                        || reclose_supervision_cond_in || win_if.expired;
  assign win_if.run   = (sup_st_q == bcl_pkg::BCL_SUP_SEAL) && !win_off;
  assign win_if.limit = 18'(win_q * `BCL_PI_PER_CYC);

  // Qualified reclose: timeout plus supervision condition
  always_comb begin
    if (win_zero) begin
      recl = oi_pend_q && reclose_supervision_cond_in;
    end else begin
      recl = ((oi_pend_q && seal_ok) || (sup_st_q == bcl_pkg::BCL_SUP_SEAL))
             && reclose_supervision_cond_in;
    end
  end

  // Failure: single check fails, or the window runs out
  assign sfail_d = win_zero ? (oi_pend_q && !reclose_supervision_cond_in)
                            : ((sup_st_q == bcl_pkg::BCL_SUP_SEAL) && win_if.expired
                               && !reclose_supervision_cond_in);

  // Seal waits for the condition; with the window OFF it waits indefinitely
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      sup_st_q <= bcl_pkg::BCL_SUP_IDLE;
    end else if (tick_q) begin
      unique case (sup_st_q)
        bcl_pkg::BCL_SUP_IDLE: begin
          if (!win_zero && oi_pend_q && seal_ok && !reclose_supervision_cond_in) begin
            sup_st_q <= bcl_pkg::BCL_SUP_SEAL;
          end
        end
        bcl_pkg::BCL_SUP_SEAL: begin
          if (sup_clr) begin
            sup_st_q <= bcl_pkg::BCL_SUP_IDLE;
          end
        end
      endcase
    end
  end

  // One-interval failure pulse, which drives the reclosing relay to lockout
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      sfail_q <= 1'b0;
    end else if (tick_q) begin
      sfail_q <= sfail_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Close latch and close failure timer
  logic cf_q;
  logic set_ok;
  logic set_close;
  logic clr_close;
  logic close_d;

  assign set_ok    = !ul_eq && !bkr_q && !ri_rise && !cf_q && !inop;
  assign set_close = set_ok && (recl || cl_rise);
  assign clr_close = ul_eq || bkr_q || ri_rise || cf_q || inop;
  assign close_d   = set_close || (close_q && !clr_close);

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      close_q <= 1'b0;
    end else if (tick_q) begin
      close_q <= close_d;
    end
  end

  // Timer runs while closing unless the delay is OFF
  assign cf_if.run   = close_q && !cfd_off;
  assign cf_if.limit = 18'(cfd_q * `BCL_PI_PER_CYC);
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cf_q <= 1'b0;
    end else if (tick_q) begin
      cf_q <= cf_if.expired;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt status and read port
  logic [3:0]  irq_stat_q;
  logic [3:0]  irq_ev;
  logic        irq_q;
  logic [31:0] rdata_q;

  assign irq_ev[`BCL_IRQ_CLOSE] = tick_q && close_d && !close_q;
  assign irq_ev[`BCL_IRQ_CF]    = tick_q && cf_if.expired && !cf_q;
  assign irq_ev[`BCL_IRQ_SF]    = tick_q && sfail_d;
  assign irq_ev[`BCL_IRQ_BKR]   = tick_q && (bkr_d != bkr_q);

  // Read clears; an event in the same cycle survives the clear
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      irq_stat_q <= 4'h0;
      irq_q      <= 1'b0;
    end else begin
      irq_stat_q <= (reg_rd_in && bcl_hit(reg_addr_in, `BCL_ADR_IRQ) ? 4'h0 : irq_stat_q) | irq_ev;
      irq_q      <= |(irq_stat_q & mask_q);
    end
  end

  // Read data stand one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_q <= 32'h0000_0000;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        `BCL_ADR_CTRL: rdata_q <= {24'h00_0000, ctrl_q};
        `BCL_ADR_CFD:  rdata_q <= {16'h0000, cfd_q};
        `BCL_ADR_DEB:  rdata_q <= {16'h0000, deb_q};
        `BCL_ADR_WIN:  rdata_q <= {16'h0000, win_q};
        `BCL_ADR_STAT: rdata_q <= {26'h000_0000, inop, reclose_lockout_in, sup_st_q, cf_q, close_q, bkr_q};
        `BCL_ADR_IRQ:  rdata_q <= {28'h000_0000, irq_stat_q};
        `BCL_ADR_MASK: rdata_q <= {28'h000_0000, mask_q};
        default:       rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops
  assign close_output_contact_out   = close_q;
  assign breaker_closed_status_out  = bkr_q;
  assign close_failure_flag_out     = cf_q;
  assign close_cmd_pulse_out        = cc_q;
  assign supervision_fail_pulse_out = sfail_q;
  assign reclose_defeat_out         = defeat_q;
  assign irq_out                    = irq_q;
  assign reg_rdata_out              = rdata_q;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_inop_blocks;
    @(posedge clk_sys_in) disable iff (rst_in) (tick_q && inop) |=> !close_q;
  endproperty
  a_inop_blocks: assert property (p_inop_blocks) else $error("close set while logic defeated");

  property p_drop_delay;
    @(posedge clk_sys_in) disable iff (rst_in) $fell(bkr_q) |-> $past(drop_if.expired);
  endproperty
  a_drop_delay: assert property (p_drop_delay) else $error("breaker dropped without half-cycle delay");

  property p_set_guard;
    @(posedge clk_sys_in) disable iff (rst_in) $rose(close_q) |-> $past(!ul_eq && !bkr_q && !ri_rise && !cf_q);
  endproperty
  a_set_guard: assert property (p_set_guard) else $error("close set with a blocking condition");

  property p_set_cause;
    @(posedge clk_sys_in) disable iff (rst_in) (tick_q && set_ok && (recl || cl_rise)) |=> close_q;
  endproperty
  a_set_cause: assert property (p_set_cause) else $error("close not set on request");

  property p_hold;
    @(posedge clk_sys_in) disable iff (rst_in) (close_q && !(tick_q && clr_close)) |=> close_q;
  endproperty
  a_hold: assert property (p_hold) else $error("close dropped without unlatch cause");

  property p_cfd_off;
    @(posedge clk_sys_in) disable iff (rst_in) $rose(cf_q) |-> $past(!cfd_off && close_q);
  endproperty
  a_cfd_off: assert property (p_cfd_off) else $error("close failure with timer off");

  property p_cf_drop;
    @(posedge clk_sys_in) disable iff (rst_in) (tick_q && cf_q) |=> !close_q;
  endproperty
  a_cf_drop: assert property (p_cf_drop) else $error("close failure did not drop close");

  property p_cc_tick;
    @(posedge clk_sys_in) disable iff (rst_in) $changed(cc_q) |-> $past(tick_q);
  endproperty
  a_cc_tick: assert property (p_cc_tick) else $error("command pulse not aligned to interval");

  property p_trip_prio;
    @(posedge clk_sys_in) disable iff (rst_in)
      (tick_q && ul_src == bcl_pkg::BCL_UL_TRIP && trip_in) |=> !close_q;
  endproperty
  a_trip_prio: assert property (p_trip_prio) else $error("close high during trip");

  property p_sf_zero;
    @(posedge clk_sys_in) disable iff (rst_in)
      (tick_q && win_zero && oi_pend_q && !reclose_supervision_cond_in) |=> (sfail_q && !close_q);
  endproperty
  a_sf_zero: assert property (p_sf_zero) else $error("single supervision check failure missed");

  cover property (@(posedge clk_sys_in) disable iff (rst_in) $rose(close_q) && cl_prev_q);
  cover property (@(posedge clk_sys_in) disable iff (rst_in) $rose(close_q) && sup_st_q == bcl_pkg::BCL_SUP_SEAL);
  cover property (@(posedge clk_sys_in) disable iff (rst_in) $rose(cf_q));
  cover property (@(posedge clk_sys_in) disable iff (rst_in) $rose(sfail_q));
endmodule

// *** hdl/bcl_defs.svh ***
// Constants for the breaker close latch logic: offsets, fields, reset values, timing
`ifndef BCL_DEFS_SVH
`define BCL_DEFS_SVH

// Timing: system clock period and processing interval (quarter power cycle at 60 Hz)
`define BCL_CLK_NS        25
`define BCL_PI_NS         4166667
`define BCL_PI_PER_CYC    4
// Half-cycle breaker dropout, in intervals (0.5 cycle)
`define BCL_DROPOUT_PI    (`BCL_PI_PER_CYC / 2)

// Register byte addresses
`define BCL_ADR_CTRL      8'h00
`define BCL_ADR_CFD       8'h04
`define BCL_ADR_DEB       8'h08
`define BCL_ADR_WIN       8'h0c
`define BCL_ADR_CMD       8'h10
`define BCL_ADR_STAT      8'h14
`define BCL_ADR_IRQ       8'h18
`define BCL_ADR_MASK      8'h1c

// Control register fields
`define BCL_CTL_BKR       1:0
`define BCL_CTL_CL        2
`define BCL_CTL_UL        4:3
`define BCL_CTL_CFD_OFF   5
`define BCL_CTL_WIN_OFF   6
`define BCL_CMD_CLOSE     0

// Reset values
`define BCL_CTRL_RST      8'h01
`define BCL_CFD_RST       16'h003c
`define BCL_DEB_RST       16'h0001
`define BCL_WIN_RST       16'h0000
`define BCL_MASK_RST      4'h0

// Interrupt status bit positions
`define BCL_IRQ_CLOSE     0
`define BCL_IRQ_CF        1
`define BCL_IRQ_SF        2
`define BCL_IRQ_BKR       3

`endif

// *** hdl/bcl_pkg.sv ***
// Types shared by the breaker close latch logic
package bcl_pkg;
  // Breaker status equation source
  typedef enum logic [1:0] {
    BCL_BKR_ZERO = 2'b00,
    BCL_BKR_NORM = 2'b01,
    BCL_BKR_INV  = 2'b10,
    BCL_BKR_ONE  = 2'b11
  } bcl_bkr_src_t;
  // Close unlatch equation source
  typedef enum logic [1:0] {
    BCL_UL_TRIP = 2'b00,
    BCL_UL_ONE  = 2'b01,
    BCL_UL_ZERO = 2'b10,
    BCL_UL_EXT  = 2'b11
  } bcl_ul_src_t;
  // Reclose supervision seal state
  typedef enum logic {
    BCL_SUP_IDLE = 1'b0,
    BCL_SUP_SEAL = 1'b1
  } bcl_sup_st_t;
endpackage

// *** hdl/bcl_tmr_if.sv ***
// Control and result signals of one interval timer
interface bcl_tmr_if #(parameter int LW = 18);
  logic          run;
  logic [LW-1:0] limit;
  logic          expired;
  modport ctl (output run, output limit, input expired);
  modport tmr (input run, input limit, output expired);
endinterface

// *** hdl/bcl_timer.sv ***
// Interval-tick timer: counts ticks while run is high
module bcl_timer #(
  parameter int LW = 18
) (
  // Clock and reset
  input  wire logic clk_sys_in,
  input  wire logic rst_in,
  // Interval tick
  input  wire logic tick_in,
  // Timer control
  bcl_tmr_if.tmr    tif
);
  logic [LW-1:0] cnt_q;

  // Restarts whenever run drops, so a glitch in the condition restarts timing
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= '0;
    end else if (!tif.run) begin
      cnt_q <= '0;
    end else if (tick_in && (cnt_q < tif.limit)) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Level while this tick completes the count, so a consumer acting on the tick sees
  // exactly limit ticks of run; limit zero or one expires at the first tick
  assign tif.expired = tif.run && (({1'b0, cnt_q} + 1'b1) >= {1'b0, tif.limit});
endmodule

// *** bench/bcl_brk_model.sv ***
// Breaker model: auxiliary a-contact closes after the close coil is held for a mechanism delay and opens on the trip coil
module bcl_brk_model #(
  parameter int CLOSE_CLKS = 6
) (
  // Clock and reset
  input  wire logic clk_sys_in,
  input  wire logic rst_in,
  // Coils and a stuck mechanism
  input  wire logic close_coil_in,
  input  wire logic trip_coil_in,
  input  wire logic stuck_in,
  // Auxiliary contact
  output logic      aux_a_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt_q;
  // A stuck breaker ignores its close coil, which is how a close failure is provoked
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q     <= 0;
      aux_a_out <= 1'b0;
    end else if (trip_coil_in) begin
      cnt_q     <= 0;
      aux_a_out <= 1'b0;
    end else if (close_coil_in && !stuck_in) begin
      cnt_q <= cnt_q + 1;
      if (cnt_q == CLOSE_CLKS - 1) aux_a_out <= 1'b1;
    end else begin
      cnt_q <= 0;
    end
  end
endmodule

// *** bench/testbench.sv ***
// Self-checking bench for the breaker close latch logic
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 4;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wd = 32'h0, rdat, v;
  logic        wr = 1'b0, rd = 1'b0, trip = 1'b0, ri = 1'b0, oit = 1'b0, cond = 1'b0, stuck = 1'b0;
  logic        aux, cls, bst, cf, cc, sf, dfx, irq, f;
  int          mismatches = 0, n_compared = 0, n;
  //////////////////////////////////////////////////////////////////////////////
  bcl_top #(.TICK_CLKS(TK)) dut_u (
    .clk_sys_in(clk), .rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdat), .first_opto_input_in(aux), .trip_in(trip),
    .close_ext_in(1'b0), .unlatch_ext_in(1'b0), .reclose_initiate_in(ri), .reclose_oi_timeout_in(oit),
    .reclose_supervision_cond_in(cond), .reclose_lockout_in(1'b0), .close_output_contact_out(cls),
    .breaker_closed_status_out(bst), .close_failure_flag_out(cf), .close_cmd_pulse_out(cc),
    .supervision_fail_pulse_out(sf), .reclose_defeat_out(dfx), .irq_out(irq));
  bcl_brk_model dut_brk (.clk_sys_in(clk), .rst_in(rst), .close_coil_in(cls), .trip_coil_in(trip),
    .stuck_in(stuck), .aux_a_out(aux));
  // Clock at 40 MHz
  initial forever #12.5 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Bus cycles start on an edge; read data are taken mid-cycle, away from the edge
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) {addr, wd, wr} <= {a, d, 1'b1};
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk) {addr, rd} <= {a, 1'b1};
    @(posedge clk) rd <= 1'b0;
    @(negedge clk) d = rdat;
  endtask
  task automatic wt(input string nm, ref logic s, input logic val, input int lim);
    for (int i = 0; i < lim && s !== val; i++) @(negedge clk);
    chk(nm, s, val);
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Watchdog: the whole sequence needs well under a thousand clocks
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_of_test();
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    static logic [7:0]  ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h1c, 8'h20};
    static logic [31:0] rv [6] = '{32'h1, 32'h3c, 32'h1, 32'h0, 32'h0, 32'h0};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    foreach (ra[i]) begin
      rd_reg(ra[i], v);
      chk("reset_value", v, rv[i]);
    end
    $display("test reset_values done");
    // Command close: one-interval pulse, latch, breaker closes, latch drops
    wr_reg(8'h1c, 32'hf);
    wr_reg(8'h10, 32'h1);
    wt("cmd_pulse", cc, 1'b1, 3 * TK);
    for (n = 0; cc === 1'b1 && n < 9 * TK; n++) @(negedge clk);
    chk("cmd_pulse_width", n, TK);
    wt("close_set", cls, 1'b1, 3 * TK);
    wt("status_pickup", bst, 1'b1, 6 * TK);
    wt("close_unlatch", cls, 1'b0, 3 * TK);
    chk("irq_level", irq, 1'b1);
    rd_reg(8'h18, v);
    chk("irq_events", v & 32'h9, 32'h9);
    rd_reg(8'h18, v);
    chk("irq_cleared", v, 32'h0);
    $display("test close_cmd done");
    // Trip opens the breaker; dropout is slower by the half-cycle timer
    @(posedge clk) trip <= 1'b1;
    for (n = 0; bst === 1'b1 && n < 8 * TK; n++) @(negedge clk);
    chk("dropout_time", n inside {[2 * TK : 4 * TK + 6]}, 1'b1);
    wr_reg(8'h10, 32'h1);
    f = 1'b0;
    repeat (6 * TK) @(negedge clk) f |= cls;
    chk("trip_blocks", f, 1'b0);
    $display("test trip_priority done");
    // Stuck breaker with a one-cycle failure delay
    @(posedge clk) {trip, stuck} <= 2'b01;
    wr_reg(8'h04, 32'h1);
    wr_reg(8'h10, 32'h1);
    wt("close_set", cls, 1'b1, 3 * TK);
    f = 1'b0;
    for (n = 0; cls === 1'b1 && n < 12 * TK; n++) @(negedge clk) f |= cf;
    chk("cf_width", n inside {[4 * TK : 6 * TK + 2]}, 1'b1);
    chk("cf_flag", f, 1'b1);
    $display("test close_failure done");
    // Failure timer off: close stands until reclose initiate rises
    wr_reg(8'h00, 32'h21);
    wr_reg(8'h10, 32'h1);
    wt("close_set", cls, 1'b1, 3 * TK);
    f = 1'b1;
    repeat (10 * TK) @(negedge clk) f &= cls;
    chk("standing_close", f, 1'b1);
    @(posedge clk) ri <= 1'b1;
    wt("ri_unlatch", cls, 1'b0, 3 * TK);
    $display("test cfd_off done");
    // Zero window: low condition fails once, with no reclose
    wr_reg(8'h00, 32'h1);
    @(posedge clk) {ri, oit} <= 2'b01;
    repeat (TK) @(posedge clk);
    oit <= 1'b0;
    wt("sup_fail", sf, 1'b1, 3 * TK);
    chk("no_reclose", cls, 1'b0);
    // One-cycle window: the timeout seals, then fails when the window runs out; back at zero window, high condition recloses
    wr_reg(8'h0c, 32'h1);
    @(posedge clk) oit <= 1'b1;
    @(posedge clk) oit <= 1'b0;
    repeat (2 * TK) @(negedge clk);
    rd_reg(8'h14, v);
    chk("sealed", v & 32'h8, 32'h8);
    chk("window_early_fail", sf, 1'b0);
    wt("window_fail", sf, 1'b1, 5 * TK);
    chk("window_no_reclose", cls, 1'b0);
    wr_reg(8'h0c, 32'h0);
    @(posedge clk) {cond, oit, stuck} <= 3'b110;
    repeat (TK) @(posedge clk);
    oit <= 1'b0;
    wt("reclose", cls, 1'b1, 3 * TK);
    wt("closed_unlatch", cls, 1'b0, 8 * TK);
    $display("test supervision done");
    // Defeat settings and the inverted contact
    wr_reg(8'h00, 32'h0);
    @(posedge clk) @(negedge clk) chk("defeat_zero", dfx, 1'b1);
    wr_reg(8'h00, 32'h9);
    @(posedge clk) @(negedge clk) chk("defeat_one", dfx, 1'b1);
    wr_reg(8'h00, 32'h2);
    @(posedge clk) @(negedge clk) chk("defeat_off", dfx, 1'b0);
    wt("inverted", bst, 1'b0, 6 * TK);
    $display("test defeat done");
    end_of_test();
  end
endmodule
